/* File: sim/fpt_fan_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Fan drive stage and tach sensor: measures the drive pin and makes tach pulses.
module fpt_fan_model (
   input  wire logic        clk_sys_i, // System clock.
   input  wire logic        fan_i,     // Fan drive pin.
   input  wire logic        run_i,     // Fan turning.
   input  wire logic [15:0] hi_i,      // Tach high cycles.
   input  wire logic [15:0] lo_i,      // Tach low cycles.
   output logic             tach_o,    // Tach sensor pin.
   output logic [15:0]      period_o,  // Last drive period in cycles.
   output logic [15:0]      high_o     // Last drive high time in cycles.
);
   logic        fan_q  = 1'b0;
   logic [15:0] cnt    = 16'h0000;
   logic [15:0] hcnt   = 16'h0000;
   logic [15:0] ph     = 16'h0000;
   initial tach_o   = 1'b1;
   initial period_o = 16'h0000;
   initial high_o   = 16'h0000;
   //////////////////////////////////////////////////////////////////////
   // Both counts restart at each rising drive edge, so they cover one period.
   always @(posedge clk_sys_i) begin
      fan_q <= fan_i;
      if (fan_i && !fan_q) begin
         period_o <= cnt;
         high_o <= hcnt;
         cnt <= 16'h0001;
         hcnt <= 16'h0001;
      end else begin
         cnt <= cnt + 16'h0001;
         hcnt <= hcnt + {15'h0000, fan_i};
      end
   end
   //////////////////////////////////////////////////////////////////////
   // A stopped fan leaves the pulled-up tach line high, so no edge is seen.
   always @(posedge clk_sys_i) begin
      ph <= (!run_i || ph == hi_i + lo_i - 16'h0001) ? 16'h0000 : ph + 16'h0001;
      tach_o <= !run_i || ph < hi_i;
   end
endmodule
`default_nettype wire

/* File: sim/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench
   import fpt_pkg::*;
;
   logic        clk_sys_i = 1'b0;
   logic        reset_i   = 1'b1;
   logic        psel      = 1'b0;
   logic        penable   = 1'b0;
   logic        pwrite    = 1'b0;
   logic        run       = 1'b0;
   logic [7:0]  paddr     = 8'h00;
   logic [31:0] pwdata    = 32'h0000_0000;
   logic [15:0] hi        = 16'h0000;
   logic [15:0] lo        = 16'h0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        tach;
   logic        fan;
   logic [15:0] per;
   logic [15:0] hig;
   int          err_count = 0;
   int          n_tests   = 0;
   int          cyc       = 0;
   //////////////////////////////////////////////////////////////////////
   // Clock, device and fan model.
   always #50 clk_sys_i = ~clk_sys_i;
   fpt_fan fpt_fan_i (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .tach_i(tach),
      .fan_drive_output_o(fan));
   fpt_fan_model fpt_fan_model_i (.clk_sys_i(clk_sys_i), .fan_i(fan), .run_i(run),
      .hi_i(hi), .lo_i(lo), .tach_o(tach), .period_o(per), .high_o(hig));
   //////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // A hang is cut short well after the longest expected run.
   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc == 40000) begin
         err_count++;
         tally_and_finish;
      end
   end
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One transfer, entered just after an edge; an idle cycle follows so that
   // back-to-back calls never assign psel twice in one time step.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      do @(posedge clk_sys_i); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask
   //////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      logic [31:0] q;
      logic        e;
      apb(1'b0, FPT_ADDR_DRIVE, 32'h0000_0000, q, e);
      chk("drive reset", {24'h00_0000, FPT_DRIVE_RESET}, q);
      apb(1'b0, FPT_ADDR_CONTROL, 32'h0000_0000, q, e);
      chk("control reset", 32'h0001_0001, q);
      apb(1'b1, FPT_ADDR_DRIVE, 32'hFFFF_FFFF, q, e);
      chk("drive write error", 32'h0000_0000, 32'(e));
      apb(1'b0, FPT_ADDR_DRIVE, 32'h0000_0000, q, e);
      chk("drive readback", 32'h0000_00FF, q);
      apb(1'b1, FPT_ADDR_TACH, 32'h0000_1234, q, e);
      chk("tach write error", 32'h0000_0000, 32'(e));
      apb(1'b0, 8'h0C, 32'h0000_0000, q, e);
      chk("unmapped error", 32'h0000_0001, 32'(e));
      chk("unmapped data", 32'h0000_0000, q);
      $display("test registers done");
   endtask
   // The pin must keep one level for 200 cycles once the write has landed.
   task automatic hold_chk(input string nm, input logic lvl);
      logic seen;
      seen = lvl;
      repeat (4) @(posedge clk_sys_i);
      repeat (200) begin
         @(posedge clk_sys_i);
         if (fan !== lvl) seen = fan;
      end
      chk(nm, 32'(lvl), 32'(seen));
   endtask
   task automatic t_levels;
      wr(FPT_ADDR_CONTROL, 32'h0001_0001);
      wr(FPT_ADDR_DRIVE, 32'h0000_0000);
      hold_chk("zero duty low", 1'b0);
      wr(FPT_ADDR_DRIVE, 32'h0000_0001);
      hold_chk("force over zero duty", 1'b1);
      wr(FPT_ADDR_DRIVE, 32'h0000_007F);
      hold_chk("force over full duty", 1'b1);
      $display("test levels done");
   endtask
   // Rates never fall, so the step divider never has to wrap a larger count.
   task automatic t_duty;
      int r[4] = '{1, 1, 2, 3};
      int d[4] = '{1, 63, 17, 32};
      foreach (r[i]) begin
         wr(FPT_ADDR_CONTROL, 32'h0001_0000 | 32'(r[i]));
         wr(FPT_ADDR_DRIVE, 32'(d[i] * 2));
         repeat (200 * r[i] + 10) @(posedge clk_sys_i);
         chk("pwm period", 32'(64 * r[i]), 32'(per));
         chk("pwm high time", 32'(d[i] * r[i]), 32'(hig));
      end
      $display("test duty done");
   endtask
   task automatic t_tach(input int dv, input int ht, input int lt);
      logic [31:0] q;
      logic        e;
      run <= 1'b0;
      wr(FPT_ADDR_CONTROL, (32'(dv) << 16) | 32'h0000_0001);
      hi <= 16'(FPT_TACH_BASE_CYC * dv * ht);
      lo <= 16'(FPT_TACH_BASE_CYC * dv * lt);
      run <= 1'b1;
      repeat (3 * FPT_TACH_BASE_CYC * dv * (ht + lt) + 20) @(posedge clk_sys_i);
      apb(1'b0, FPT_ADDR_TACH, 32'h0000_0000, q, e);
      chk("tach count", 32'(ht + lt), q);
      $display("test tach done");
   endtask
   //////////////////////////////////////////////////////////////////////
   // Reset for four cycles, then the scenarios in turn.
   initial begin
      repeat (4) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      @(posedge clk_sys_i);
      t_regs;
      t_levels;
      t_duty;
      t_tach(1, 3, 1);
      t_tach(2, 3, 5);
      t_tach(1, 5, 2);
      tally_and_finish;
   end
endmodule
`default_nettype wire

/* File: src/fpt_fan.sv */
// Contract
// - Force-high bit zero of drive setting holds fan output high.
// - With force bit clear, duty comes from drive bits six down to one.
// - Duty field zero with force clear keeps fan output low.
// - Nonzero duty gives steps of one sixty-fourth of the period.
// - Period is sixty-four steps of a rate chosen by control setting.
// - High time spans the range the period and duty settings allow.
// - Tach counter ticks every base unit times the control divisor.
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module fpt_fan
   import fpt_pkg::*;
(
   input  wire logic        clk_sys_i,  // System clock, 10 MHz.
   input  wire logic        reset_i,    // Synchronous reset, active high.
   input  wire logic        psel,       // APB select.
   input  wire logic        penable,    // APB access phase.
   input  wire logic        pwrite,     // APB direction, high for write.
   input  wire logic [7:0]  paddr,      // APB byte address.
   input  wire logic [31:0] pwdata,     // APB write data.
   output logic [31:0]      prdata,     // APB read data.
   output logic             pready,     // APB ready.
   output logic             pslverr,    // APB error on unmapped address.
   input  wire logic        tach_i,     // Fan tach sensor pin.
   output logic             fan_drive_output_o // Fan drive pin.
);

   fpt_req_s                  req;
   logic [7:0]                fan_drive_setting;
   logic [FPT_RATE_W-1:0]     rate_div;
   logic [FPT_TACH_CLOCK_DIVISOR_W-1:0]     tach_clock_divisor;
   logic [FPT_TACH_CNT_W-1:0] tach_run;
   logic [FPT_TACH_CNT_W-1:0] tach_speed;
   logic [FPT_DUTY_W-1:0]     pwm_phase;
   logic                      step_tick;
   logic                      base_tick;
   logic                      tach_tick;
   logic [FPT_TACH_CLOCK_DIVISOR_W-1:0]     tach_clock_divisor_cnt;
   logic                      tach_meta;
   logic                      tach_sync;
   logic                      tach_prev;
   logic                      access;
   logic                      complete;
   logic                      next_pwm;

   assign req    = '{wr: pwrite, addr: paddr, wdata: pwdata};
   assign access   = psel && penable && !pready;
   assign complete = psel && penable && pready;

   // Decodes whether an address maps to a register.
   function automatic logic fpt_mapped(input logic [7:0] a);
      return (a == FPT_ADDR_DRIVE) || (a == FPT_ADDR_CONTROL) || (a == FPT_ADDR_TACH);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // APB slave: one wait state, so the access phase always ends on its second edge.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (access) begin
         pready  <= 1'b1;
         pslverr <= !fpt_mapped(req.addr);
         prdata  <= 32'h0000_0000;
         if (!req.wr) begin
            case (req.addr)
               FPT_ADDR_DRIVE:   prdata <= {24'h00_0000, fan_drive_setting};
               FPT_ADDR_CONTROL: prdata <= {8'h00, tach_clock_divisor, rate_div};
               FPT_ADDR_TACH:    prdata <= {16'h0000, tach_speed};
               default:          prdata <= 32'h0000_0000;
            endcase
         end
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // Settings take effect only at the completing edge of a write, where the master sees pready.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         fan_drive_setting  <= FPT_DRIVE_RESET;
         rate_div           <= FPT_RATE_RESET;
         tach_clock_divisor <= FPT_TACH_CLOCK_DIVISOR_RESET;
      end else if (complete && req.wr) begin
         if (req.addr == FPT_ADDR_DRIVE) begin
            fan_drive_setting <= req.wdata[7:0];
         end
         if (req.addr == FPT_ADDR_CONTROL) begin
            rate_div           <= req.wdata[FPT_CTRL_RATE_LSB +: FPT_RATE_W];
            tach_clock_divisor <= req.wdata[FPT_CTRL_TACH_CLOCK_DIVISOR_LSB +: FPT_TACH_CLOCK_DIVISOR_W];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // PWM step rate; sixty-four steps make one period.
   fpt_tick #(.W(FPT_RATE_W)) u_step (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .div_i     (rate_div),
      .tick_o    (step_tick)
   );

   // Phase counter advances one step per tick.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         pwm_phase <= '0;
      end else if (step_tick) begin
         pwm_phase <= pwm_phase + FPT_DUTY_W'(1);
      end
   end

   // Output is high while phase is below duty, so duty/64 of the period is high.
   always_comb begin
      if (fan_drive_setting[FPT_DRIVE_FORCE_BIT]) begin
         next_pwm = 1'b1;
      end else begin
         next_pwm = pwm_phase < fan_drive_setting[FPT_DRIVE_DUTY_LSB +: FPT_DUTY_W];
      end
   end

   // Registered so the pin never glitches on a setting change.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         fan_drive_output_o <= 1'b0;
      end else begin
         fan_drive_output_o <= next_pwm;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Base time unit tick of about 30.5 us; truncation to whole cycles costs under 1 %.
   fpt_tick #(.W(16)) u_base (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .div_i     (16'(FPT_TACH_BASE_CYC)),
      .tick_o    (base_tick)
   );

   // Divides the base tick by the programmed divisor.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         tach_clock_divisor_cnt  <= '0;
         tach_tick <= 1'b0;
      end else begin
         tach_tick <= 1'b0;
         if (base_tick) begin
            if (tach_clock_divisor_cnt + FPT_TACH_CLOCK_DIVISOR_W'(1) >= tach_clock_divisor) begin
               tach_clock_divisor_cnt  <= '0;
               tach_tick <= 1'b1;
            end else begin
               tach_clock_divisor_cnt <= tach_clock_divisor_cnt + FPT_TACH_CLOCK_DIVISOR_W'(1);
            end
         end
      end
   end

   // Tach pin comes from outside, so it passes two flops first.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         tach_meta <= 1'b0;
         tach_sync <= 1'b0;
         tach_prev <= 1'b0;
      end else begin
         tach_meta <= tach_i;
         tach_sync <= tach_meta;
         tach_prev <= tach_sync;
      end
   end

   // Counts tach ticks between rising edges; saturates on a stalled fan.
   // Shorter pulses than the sensor minimum still count but lose resolution.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         tach_run   <= '0;
         tach_speed <= '0;
      end else if (tach_sync && !tach_prev) begin
         // A tick in the edge cycle still closes the interval, so none is lost.
         if (tach_tick && tach_run != '1) begin
            tach_speed <= tach_run + FPT_TACH_CNT_W'(1);
         end else begin
            tach_speed <= tach_run;
         end
         tach_run   <= '0;
      end else if (tach_tick && tach_run != '1) begin
         tach_run <= tach_run + FPT_TACH_CNT_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   force_high_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      fan_drive_setting[FPT_DRIVE_FORCE_BIT] |=> fan_drive_output_o)
      else $error("fan output not high while forced");

   duty_zero_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      fan_drive_setting[6:0] == 7'h00 ##1 fan_drive_setting[6:0] == 7'h00
      |-> !fan_drive_output_o)
      else $error("fan output high with zero duty");

   duty_cmp_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      !fan_drive_setting[0] |=> fan_drive_output_o ==
      ($past(pwm_phase) < $past(fan_drive_setting[6:1])))
      else $error("fan output disagrees with duty");

   full_duty_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      fan_drive_setting == 8'h7e && $stable(fan_drive_setting) && pwm_phase == 6'd63
      |=> !fan_drive_output_o)
      else $error("duty 63 did not drop for last step");

   phase_step_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      step_tick |=> pwm_phase == $past(pwm_phase) + 6'd1)
      else $error("pwm phase did not advance");

   tach_tick_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      tach_tick |-> $past(base_tick))
      else $error("tach tick without base tick");

   speed_latch_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      tach_sync && !tach_prev |=> tach_run == 16'h0000 &&
      tach_speed == $past(tach_run) + 16'($past(tach_tick && tach_run != 16'hffff)))
      else $error("tach speed not latched on edge");

   apb_ready_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      psel && penable && !pready |=> pready)
      else $error("apb access not answered in one cycle");

   pwm_high_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
      !fan_drive_setting[0] && fan_drive_output_o ##1 !fan_drive_output_o);
   force_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
      fan_drive_setting[0] && fan_drive_output_o);
   tach_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
      tach_sync && !tach_prev && tach_run != 16'h0000);

endmodule
`default_nettype wire

/* File: src/fpt_pkg.sv */
package fpt_pkg;

   // Register byte addresses on the APB slave.
   localparam logic [7:0] FPT_ADDR_DRIVE   = 8'h00;
   localparam logic [7:0] FPT_ADDR_CONTROL = 8'h04;
   localparam logic [7:0] FPT_ADDR_TACH    = 8'h08;

   // Field positions in the fan drive setting.
   localparam int FPT_DRIVE_FORCE_BIT = 0;
   localparam int FPT_DRIVE_DUTY_LSB  = 1;
   localparam int FPT_DUTY_W          = 6;

   // Field positions in the fan control setting.
   localparam int FPT_CTRL_RATE_LSB = 0;
   localparam int FPT_RATE_W        = 16;
   localparam int FPT_CTRL_TACH_CLOCK_DIVISOR_LSB = 16;
   localparam int FPT_TACH_CLOCK_DIVISOR_W        = 8;

   // Reset values.
   localparam logic [7:0]  FPT_DRIVE_RESET = 8'h00;
   localparam logic [15:0] FPT_RATE_RESET  = 16'h0001;
   localparam logic [7:0]  FPT_TACH_CLOCK_DIVISOR_RESET  = 8'h01;

   // Tach base time unit: 30.52 us, kept in nanoseconds.
   localparam int FPT_CLK_NS         = 100;
   localparam int FPT_TACH_BASE_NS   = 30520;
   localparam int FPT_TACH_BASE_CYC  = FPT_TACH_BASE_NS / FPT_CLK_NS;
   localparam int FPT_TACH_CNT_W     = 16;

   // One APB request bundled for the register decode.
   typedef struct packed {
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } fpt_req_s;

endpackage

/* File: src/fpt_tick.sv */
`timescale 1ns/100ps
`default_nettype none
module fpt_tick
   import fpt_pkg::*;
#(
   parameter int W = 16
) (
   input  wire logic         clk_sys_i, // System clock.
   input  wire logic         reset_i,   // Synchronous reset, active high.
   input  wire logic [W-1:0] div_i,     // Cycles per tick, zero acts as one.
   output logic              tick_o     // One-cycle enable pulse.
);

   logic [W-1:0] count;

   // Counts down and pulses once per wrap so every slower rate stays on one clock.
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         count  <= '0;
         tick_o <= 1'b0;
      end else if (count == '0) begin
         count  <= (div_i == '0) ? '0 : div_i - W'(1);
         tick_o <= 1'b1;
      end else begin
         count  <= count - W'(1);
         tick_o <= 1'b0;
      end
   end

endmodule
`default_nettype wire
